// >>> rtccal_bench.sv
// Self-checking bench for the clock control and trim register with value window.
// Assumes rtccal_pkg and rtccal_top are compiled first; timebase shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module rtccal_bench;
  import rtccal_pkg::*;
  localparam int HALF = 64;
  localparam int RIP  = 4;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [3:0]  adr     = 4'h0;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] dat     = 32'h0;
  wire  [31:0] dat_o;
  wire         ack;
  wire         en;
  wire         oe;
  wire  [7:0]  trim;
  wire         half;
  wire         rip;
  wire         tick;
  logic [15:0] ctrl_m;
  logic [15:0] hi_m[4];
  logic [15:0] lo_m[4];
  logic [15:0] r;
  int          failures  = 0;
  int          tests_run = 0;
  int          nh;
  int          nr;
  int          nt;

  rtccal_top #(.HALF_SEC_CYCLES(HALF), .RIPPLE_CYCLES(RIP)) rtccal_top_i (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CLOCK_MODULE_ENABLE(en), .CLOCK_PIN_OUTPUT_ENABLE(oe), .DRIFT_TRIM(trim),
    .HALF_SECOND_PHASE(half), .ROLLOVER_RIPPLE_FLAG(rip), .SECOND_TICK(tick));

  always #25 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Classic single-cycle bus access
  // -------------------------------------------------------------
  // No cycle count assumed: only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= {16'h0000, d};
    @(posedge ref_clk);
    while (ack !== 1'b1)
      @(posedge ref_clk);
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic cw(input logic [15:0] d);
    wb(1'b1, ADDR_CTRL, d, r);
    ctrl_m = d & CTRL_WR_MASK;
  endtask

  task automatic cr();
    wb(1'b0, ADDR_CTRL, 16'h0000, r);
    chk(r, ctrl_m);
  endtask

  // Window access against the model: select, write lock, pointer step
  task automatic win(input logic w, input logic h, input logic [15:0] d);
    int p;
    p = ctrl_m[9:8];
    wb(w, h ? ADDR_VAL_HIGH : ADDR_VAL_LOW, d, r);
    if (!w)
      chk(r, h ? hi_m[p] : lo_m[p]);
    else if (ctrl_m[BIT_UNLOCK] && h)
      hi_m[p] = d;
    else if (ctrl_m[BIT_UNLOCK])
      lo_m[p] = d;
    if (p > 0)
      ctrl_m[9:8] = 2'(p - 1);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(30));
    ctrl_m = CTRL_RESET;
    for (int i = 0; i < 4; i++)
    begin
      hi_m[i] = VAL_RESET;
      lo_m[i] = VAL_RESET;
    end
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cr();
    cw(16'h7fff);
    cr();
    chk({8'h00, trim}, 16'h00ff);
    chk({14'h0, oe, en}, 16'h0002);
    for (int i = 0; i < 5; i++)
    begin
      win(1'b0, 1'(i), 16'h0000);
      cr();
    end
    cw(16'h0300);
    repeat (4) win(1'b1, 1'b1, 16'($urandom));
    for (int p = 0; p < 4; p++)
    begin
      cw(16'h2000 | 16'(p << 8));
      win(1'b1, p[0], 16'($urandom));
      win(1'b1, ~p[0], 16'($urandom));
    end
    for (int p = 0; p < 4; p++)
    begin
      cw(16'(p << 8));
      win(1'b0, 1'b1, 16'h0000);
      win(1'b0, 1'b0, 16'h0000);
    end
    cw(16'h8000);
    chk({15'h0, en}, 16'h0001);
    nh = 0;
    while (half !== 1'b1 && nh < 400)
    begin
      nh++;
      @(posedge ref_clk);
    end
    nh = 0;
    nr = 0;
    nt = 0;
    repeat (2 * HALF)
    begin
      @(posedge ref_clk);
      nh += int'(half === 1'b1);
      nr += int'(rip === 1'b1);
      nt += int'(tick === 1'b1);
    end
    chk(16'(nh), 16'(HALF));
    chk(16'(nr), 16'(RIP));
    chk(16'(nt), 16'h0001);
    wb(1'b0, ADDR_CTRL, 16'h0000, r);
    chk(r, 16'h8800);
    cw(16'h1800);
    repeat (2) @(posedge ref_clk);
    chk({14'h0, rip, half}, 16'h0000);
    cr();
    wb(1'b0, 4'hc, 16'h0000, r);
    chk(r, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> rtccal_pkg.sv
// Constants for the clock control and trim register block.
// Assumes a 32-bit classic Wishbone slave port and a 20 MHz system clock.
package rtccal_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_VAL_HIGH = 4'h4;
  localparam logic [3:0] ADDR_VAL_LOW  = 4'h8;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE    = 15;
  localparam int BIT_UNLOCK    = 13;
  localparam int BIT_RIPPLE    = 12;
  localparam int BIT_HALF_SEC  = 11;
  localparam int BIT_PIN_OE    = 10;
  localparam int PTR_LSB       = 8;
  localparam int PTR_W         = 2;
  localparam int TRIM_LSB      = 0;
  localparam int TRIM_W        = 8;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'ha7ff;
  localparam logic [15:0] VAL_RESET    = 16'h0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 20000000;
  localparam int HALF_SEC_MS     = 500;
  localparam int HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int RIPPLE_CYCLES   = 32;
  localparam int TIMER_W         = 24;
endpackage

// >>> rtccal_top.sv
// Control and trim register of the real-time clock, with value window.
// Assumes a classic Wishbone master on the system clock; counting chain lives outside.
//
// Overview of operation
// - Bit 15 enables the clock timebase; pin output enable and trim act regardless of it
// - Value writes accepted only while unlocked
// - Value registers locked after reset and clear
// - Ripple flag high near rollover
// - Ripple flag low when reads are safe
// - Half-second flag high in second half
// - Pointer selects visible value register
// - Each window access decrements the pointer
// - Pointer stops decrementing at zero
// - Unimplemented bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module rtccal_top #(
  parameter int HALF_SEC_CYCLES = rtccal_pkg::HALF_SEC_CYCLES,
  parameter int RIPPLE_CYCLES   = rtccal_pkg::RIPPLE_CYCLES
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             CLOCK_MODULE_ENABLE,
  output logic             CLOCK_PIN_OUTPUT_ENABLE,
  output logic [rtccal_pkg::TRIM_W-1:0] DRIFT_TRIM,
  output logic             HALF_SECOND_PHASE,
  output logic             ROLLOVER_RIPPLE_FLAG,
  output logic             SECOND_TICK
);
  import rtccal_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] val_high [4];
  logic [15:0] val_low  [4];
  logic [TIMER_W-1:0] half_cnt;
  logic               half_sec;

  wire             req         = WB_CYC_I && WB_STB_I;
  wire             take        = req && WB_ACK_O;
  wire             hit_ctrl    = WB_ADR_I == ADDR_CTRL;
  wire             hit_high    = WB_ADR_I == ADDR_VAL_HIGH;
  wire             hit_low     = WB_ADR_I == ADDR_VAL_LOW;
  wire             hit_win     = hit_high || hit_low;
  wire [PTR_W-1:0] ptr         = ctrl[PTR_LSB +: PTR_W];
  wire             module_en   = ctrl[BIT_ENABLE];
  wire             unlock      = ctrl[BIT_UNLOCK];
  wire [15:0]      lane_mask   = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [15:0]      wr_data     = WB_DAT_I[15:0];
  wire             ctrl_wr     = take && WB_WE_I && hit_ctrl;
  wire             val_wr      = take && WB_WE_I && hit_win && unlock;
  wire             win_access  = take && hit_win;
  wire [PTR_W-1:0] next_ptr    = (ptr == '0) ? ptr : ptr - 1'b1;
  wire [15:0]      wr_mask     = lane_mask & CTRL_WR_MASK;

  // Timebase runs only while enabled, so a disabled clock never ripples
  wire last_cycle  = half_cnt == TIMER_W'(HALF_SEC_CYCLES - 1);
  wire ripple_zone = module_en && half_sec
                     && (half_cnt >= TIMER_W'(HALF_SEC_CYCLES - RIPPLE_CYCLES));

  // Live flags replace stored bits; a write can never land there
  wire [15:0] ctrl_view = {ctrl[15:13], ripple_zone, half_sec, ctrl[10:0]};

  wire [15:0] rd_word = hit_ctrl ? ctrl_view :
                        hit_high ? val_high[ptr] :
                        hit_low  ? val_low[ptr]  : 16'h0000;

  // ---------------------------------------------------------------
  // Wishbone answer: one wait state, data latched with ack
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= req && !WB_ACK_O;
      if (req && !WB_ACK_O)
        WB_DAT_O <= {16'h0000, rd_word};
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= (ctrl & ~wr_mask) | (wr_data & wr_mask);
    else if (win_access)
      ctrl[PTR_LSB +: PTR_W] <= next_ptr;
  end

  // ---------------------------------------------------------------
  // Value window storage
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        val_high[i] <= VAL_RESET;
        val_low[i]  <= VAL_RESET;
      end
    end
    else if (val_wr)
    begin
      if (hit_high)
        val_high[ptr] <= (val_high[ptr] & ~lane_mask) | (wr_data & lane_mask);
      else
        val_low[ptr]  <= (val_low[ptr] & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  // ---------------------------------------------------------------
  // Half-second timebase
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt    <= '0;
      half_sec    <= 1'b0;
      SECOND_TICK <= 1'b0;
    end
    else if (!module_en)
    begin
      // Disabling restarts the second so phase is known on re-enable
      half_cnt    <= '0;
      half_sec    <= 1'b0;
      SECOND_TICK <= 1'b0;
    end
    else
    begin
      half_cnt    <= last_cycle ? '0 : half_cnt + 1'b1;
      SECOND_TICK <= last_cycle && half_sec;
      if (last_cycle)
        half_sec <= !half_sec;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign CLOCK_MODULE_ENABLE     = module_en;
  assign CLOCK_PIN_OUTPUT_ENABLE = ctrl[BIT_PIN_OE];
  assign DRIFT_TRIM              = ctrl[TRIM_LSB +: TRIM_W];
  assign HALF_SECOND_PHASE       = half_sec;
  assign ROLLOVER_RIPPLE_FLAG    = ripple_zone;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  wire [127:0] all_vals = {val_high[3], val_high[2], val_high[1], val_high[0],
                           val_low[3], val_low[2], val_low[1], val_low[0]};

  property p_enable_write;
    @(posedge REF_CLK) disable iff (!rst_n)
    (ctrl_wr && WB_SEL_I[1]) |=> (CLOCK_MODULE_ENABLE == $past(WB_DAT_I[15]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

  property p_locked_values;
    @(posedge REF_CLK) disable iff (!rst_n)
    (take && WB_WE_I && hit_win && !unlock) |=> $stable(all_vals);
  endproperty
  a_locked_values: assert property (p_locked_values) else $error("locked value changed");

  property p_reset_locked;
    @(posedge REF_CLK)
    !rst_n |-> (!ctrl[BIT_UNLOCK] && all_vals == '0);
  endproperty
  a_reset_locked: assert property (p_reset_locked) else $error("unlock set in reset");

  property p_ripple_before_tick;
    @(posedge REF_CLK) disable iff (!rst_n)
    $rose(SECOND_TICK) |-> $past(ROLLOVER_RIPPLE_FLAG, 2);
  endproperty
  a_ripple_before_tick: assert property (p_ripple_before_tick) else $error("no ripple flag at rollover");

  property p_ripple_safe;
    @(posedge REF_CLK) disable iff (!rst_n)
    (!CLOCK_MODULE_ENABLE || !HALF_SECOND_PHASE) |-> !ROLLOVER_RIPPLE_FLAG;
  endproperty
  a_ripple_safe: assert property (p_ripple_safe) else $error("ripple flag in safe time");

  property p_half_after_tick;
    @(posedge REF_CLK) disable iff (!rst_n)
    SECOND_TICK |-> (!HALF_SECOND_PHASE && $past(HALF_SECOND_PHASE));
  endproperty
  a_half_after_tick: assert property (p_half_after_tick) else $error("half-second phase wrong");

  property p_window_read;
    @(posedge REF_CLK) disable iff (!rst_n)
    (req && !WB_ACK_O && hit_high && !WB_WE_I) |=> (WB_DAT_O[15:0] == $past(val_high[ptr]));
  endproperty
  a_window_read: assert property (p_window_read) else $error("window read wrong entry");

  property p_ptr_step;
    @(posedge REF_CLK) disable iff (!rst_n)
    win_access |=> (ptr == (($past(ptr) == 2'h0) ? 2'h0 : $past(ptr) - 2'h1));
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");

  property p_unused_zero;
    @(posedge REF_CLK) disable iff (!rst_n)
    WB_ACK_O |-> (WB_DAT_O[31:16] == 16'h0000 && (!$past(hit_ctrl) || !WB_DAT_O[14]));
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unimplemented bits nonzero");

  property p_flags_ro;
    @(posedge REF_CLK) disable iff (!rst_n)
    (ctrl_wr && !module_en) |=> (!ROLLOVER_RIPPLE_FLAG && !HALF_SECOND_PHASE);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("read-only flag written");
endmodule
`default_nettype wire
